// ==== asrr_pkg.sv ====
/*
 * Constants, register map, field layout and carrier types of the serial
 * register bank of a dual-channel converter.
 * Assumes a 20 MHz system clock; all users reference names as asrr_pkg::x.
 */
package asrr_pkg;

    localparam int         FRAME_BITS       = 16;
    localparam int         NUM_REGS         = 48;
    localparam logic [3:0] LAST_BIT_CNT     = 4'hF;
    localparam logic [3:0] ADDR_LAST_CNT    = 4'h7;

    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_CLK_DRV     = 8'h10;
    localparam logic [7:0] ADDR_DATA_DRV    = 8'h11;
    localparam logic [7:0] ADDR_TERM        = 8'h12;
    localparam logic [7:0] ADDR_OFS_HOLD    = 8'h13;
    localparam logic [7:0] ADDR_IF_GAIN     = 8'h14;
    localparam logic [7:0] ADDR_FORMAT      = 8'h16;
    localparam logic [7:0] ADDR_FINE_GAIN   = 8'h17;
    localparam logic [7:0] ADDR_PAT_LO      = 8'h18;
    localparam logic [7:0] ADDR_PAT_HI      = 8'h19;
    localparam logic [7:0] ADDR_LAT_CORR    = 8'h1A;
    localparam logic [7:0] ADDR_FILT_CTRL   = 8'h1B;
    localparam logic [7:0] ADDR_BAND_SEL    = 8'h1D;
    localparam logic [7:0] ADDR_COEF_FIRST  = 8'h1E;
    localparam logic [7:0] ADDR_COEF_LAST   = 8'h2F;

    localparam int         READOUT_BIT      = 0;
    localparam int         SRST_BIT         = 1;
    localparam int         FORMAT_BIT       = 4;

    localparam logic [7:0] REG_RESET        = 8'h00;
    localparam logic       IF_CMOS          = 1'b1;
    localparam logic       PIN_IDLE_LVL     = 1'b0;

    localparam int         SYS_CLK_HZ       = 20_000_000;
    localparam int         PWR_UP_MS        = 7;
    localparam int         PWR_UP_CYC       = PWR_UP_MS * (SYS_CLK_HZ / 1000);

    // Writable bits of each address; everything else reads as zero
    function automatic logic [7:0] reg_mask(input logic [7:0] a);
        logic [7:0] m;
        m = 8'h00;
        unique case (a)
            ADDR_CTRL:      m = 8'h01;
            ADDR_CLK_DRV:   m = 8'hC0;
            ADDR_DATA_DRV:  m = 8'h3F;
            ADDR_TERM:      m = 8'h3F;
            ADDR_OFS_HOLD:  m = 8'h10;
            ADDR_IF_GAIN:   m = 8'hBF;
            ADDR_FORMAT:    m = 8'h1F;
            ADDR_FINE_GAIN: m = 8'h0F;
            ADDR_PAT_LO:    m = 8'hFF;
            ADDR_PAT_HI:    m = 8'h3F;
            ADDR_LAT_CORR:  m = 8'hFF;
            ADDR_FILT_CTRL: m = 8'hBF;
            ADDR_BAND_SEL:  m = 8'h03;
            default: begin
                if (a >= ADDR_COEF_FIRST && a <= ADDR_COEF_LAST) begin
                    m = 8'hFF;
                end
            end
        endcase
        return m;
    endfunction : reg_mask

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic shift_in_line;
    } asrr_ser_t;

    typedef struct packed {
        logic [1:0]  clkout_strength;
        logic [1:0]  current_double;
        logic [1:0]  lvds_current;
        logic [1:0]  data_strength;
        logic [2:0]  data_term;
        logic [2:0]  clk_term;
        logic        offset_freeze;
        logic        pin_override;
        logic        iface_sel;
        logic        coarse_gain;
        logic        ref_sel;
        logic [2:0]  pdn_mux_mode;
        logic        data_format;
        logic        byte_wise;
        logic [2:0]  test_pattern;
        logic [3:0]  fine_gain;
        logic [13:0] custom_pattern;
        logic [7:0]  lat_corr;
        logic [7:0]  filt_ctrl;
        logic [1:0]  band_sel;
    } asrr_cfg_t;

endpackage : asrr_pkg

// ==== asrr_regbank.sv ====
/*
 * Serial configuration register bank with register readback.
 * Assumes serial pins, the reset pin and the negative output clock come
 * from outside the sys_clk domain; the shift clock is far slower than sys_clk.
 */
// Function
// - Setting readback enable blocks further register writes until cleared.
// - Readback frame shifts the addressed register's eight bits out the pin.
// - Readback only in CMOS mode; LVDS mode routes negative output clock.
// - With readback disabled in CMOS mode the pin is driven to a fixed level.
// - Outputs report stable 7 ms after power-up.
// - One write updates every field of a register together.
// - Register 16 bit D4 selects two's complement or straight binary.
// - Register 14 holds override, interface, gain, reference, power modes.
// - Soft reset bit restores all defaults and clears itself.
// - Frame is 16 bits: address byte then data byte.
// - Serial input is sampled on each shift clock fall while selected.
`timescale 1ns/100ps
module asrr_regbank #(
    parameter int PWR_UP_CYC = asrr_pkg::PWR_UP_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire asrr_pkg::asrr_ser_t ser_in,
    input  wire logic               reset_pin,
    input  wire logic               output_clock_negative,
    output logic                    readback_out_pin,
    output asrr_pkg::asrr_cfg_t     cfg,
    output logic [143:0]            coef_bank,
    output logic                    outputs_stable
);

    localparam int PUW = $clog2(PWR_UP_CYC + 1);

    asrr_pkg::asrr_ser_t ser_m_q, ser_s_q;
    logic                hrst_m_q, hrst_s_q;
    logic                sclk_prev_q;
    logic [3:0]          bit_cnt_q;
    logic [15:0]         sh_q;
    logic [7:0]          regs_q [asrr_pkg::NUM_REGS];
    logic [7:0]          out_sh_q;
    logic                out_bit_q;
    logic [PUW-1:0]      pu_cnt_q;
    logic                stable_q;

    // Two-stage synchronisers; only stage two is looked at
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Shift clock idles low; a high reset value would fake a fall
            ser_m_q  <= '{sel_n: 1'b1, sclk: 1'b0, shift_in_line: 1'b0};
            ser_s_q  <= '{sel_n: 1'b1, sclk: 1'b0, shift_in_line: 1'b0};
            hrst_m_q <= 1'b0;
            hrst_s_q <= 1'b0;
        end else begin
            ser_m_q  <= ser_in;
            ser_s_q  <= ser_m_q;
            hrst_m_q <= reset_pin;
            hrst_s_q <= hrst_m_q;
        end
    end

    wire        sclk_fall = sclk_prev_q & ~ser_s_q.sclk;
    wire        sclk_rise = ~sclk_prev_q & ser_s_q.sclk;
    wire        take      = sclk_fall & ~ser_s_q.sel_n;
    wire [15:0] sh_next   = {sh_q[14:0], ser_s_q.shift_in_line};
    wire        word_done = take && (bit_cnt_q == asrr_pkg::LAST_BIT_CNT);
    wire        addr_done = take && (bit_cnt_q == asrr_pkg::ADDR_LAST_CNT);
    wire [7:0]  wr_addr   = sh_next[15:8];
    wire [7:0]  wr_data   = sh_next[7:0];
    wire        rd_en     = regs_q[0][asrr_pkg::READOUT_BIT];
    wire        cmos_mode = cfg.iface_sel == asrr_pkg::IF_CMOS;
    wire        wr_inmap  = wr_addr < 8'(asrr_pkg::NUM_REGS);
    // Control register stays writable so readback can be switched off
    wire        wr_ok     = word_done && wr_inmap &&
                            (!rd_en || wr_addr == asrr_pkg::ADDR_CTRL);
    wire        srst      = wr_ok && wr_addr == asrr_pkg::ADDR_CTRL &&
                            wr_data[asrr_pkg::SRST_BIT];
    wire [7:0]  wr_val    = wr_data & asrr_pkg::reg_mask(wr_addr);
    wire [5:0]  wr_idx    = wr_addr[5:0];
    wire [7:0]  rd_addr   = sh_next[7:0];
    wire        rd_inmap  = rd_addr < 8'(asrr_pkg::NUM_REGS);
    wire [7:0]  rd_data   = rd_inmap ? regs_q[rd_addr[5:0]] : 8'h00;
    wire        init_regs = hrst_s_q | srst;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
            bit_cnt_q   <= 4'h0;
            sh_q        <= 16'h0000;
        end else begin
            sclk_prev_q <= ser_s_q.sclk;
            if (ser_s_q.sel_n) begin
                bit_cnt_q <= 4'h0;
            end else if (take) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                sh_q      <= sh_next;
            end
        end
    end

    // Whole byte stored at once, so all fields change together
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < asrr_pkg::NUM_REGS; i++) begin
                regs_q[i] <= asrr_pkg::REG_RESET;
            end
        end else if (init_regs) begin
            for (int i = 0; i < asrr_pkg::NUM_REGS; i++) begin
                regs_q[i] <= asrr_pkg::REG_RESET;
            end
        end else if (wr_ok) begin
            regs_q[wr_idx] <= wr_val;
        end
    end

    // Bits change on rising edges so they are settled at the falling edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_sh_q  <= 8'h00;
            out_bit_q <= 1'b0;
        end else if (ser_s_q.sel_n) begin
            out_sh_q  <= 8'h00;
            out_bit_q <= 1'b0;
        end else if (addr_done) begin
            out_sh_q  <= rd_data;
        end else if (sclk_rise) begin
            if (bit_cnt_q[3]) begin
                out_bit_q <= out_sh_q[7];
                out_sh_q  <= {out_sh_q[6:0], 1'b0};
            end else begin
                out_bit_q <= 1'b0;
            end
        end
    end

    // Never tri-stated; in LVDS mode the pin is the negative output clock
    assign readback_out_pin = !cmos_mode ? output_clock_negative :
                              rd_en ? out_bit_q :
                              asrr_pkg::PIN_IDLE_LVL;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_q <= '0;
            stable_q <= 1'b0;
        end else if (!stable_q) begin
            pu_cnt_q <= pu_cnt_q + PUW'(1);
            stable_q <= pu_cnt_q == PUW'(PWR_UP_CYC - 1);
        end
    end
    assign outputs_stable = stable_q;

    assign cfg.clkout_strength = regs_q[16][7:6];
    assign cfg.current_double  = regs_q[17][5:4];
    assign cfg.lvds_current    = regs_q[17][3:2];
    assign cfg.data_strength   = regs_q[17][1:0];
    assign cfg.data_term       = regs_q[18][5:3];
    assign cfg.clk_term        = regs_q[18][2:0];
    assign cfg.offset_freeze   = regs_q[19][4];
    assign cfg.pin_override    = regs_q[20][7];
    assign cfg.iface_sel       = regs_q[20][5];
    assign cfg.coarse_gain     = regs_q[20][4];
    assign cfg.ref_sel         = regs_q[20][3];
    assign cfg.pdn_mux_mode    = regs_q[20][2:0];
    assign cfg.data_format     = regs_q[22][asrr_pkg::FORMAT_BIT];
    assign cfg.byte_wise       = regs_q[22][3];
    assign cfg.test_pattern    = regs_q[22][2:0];
    assign cfg.fine_gain       = regs_q[23][3:0];
    assign cfg.custom_pattern  = {regs_q[25][5:0], regs_q[24]};
    assign cfg.lat_corr        = regs_q[26];
    assign cfg.filt_ctrl       = regs_q[27];
    assign cfg.band_sel        = regs_q[29][1:0];

    genvar g;
    for (g = 0; g < 18; g++) begin : g_coef
        assign coef_bank[g*8 +: 8] = regs_q[30 + g];
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_WRITE_BLOCKED: assert property (
        word_done && rd_en && wr_inmap && wr_addr != asrr_pkg::ADDR_CTRL &&
        !init_regs |=> regs_q[$past(wr_idx)] == $past(regs_q[wr_idx]))
        else $error("write accepted while readback enabled");
    AST_WRITE_DISCARD: assert property (
        rd_en && !init_regs |=> $stable(regs_q[22]) && $stable(regs_q[20]))
        else $error("register changed during readback");
    AST_READ_LOAD: assert property (
        addr_done && !ser_s_q.sel_n |=> out_sh_q == $past(rd_data))
        else $error("readback data not loaded");
    AST_LVDS_PIN: assert property (
        !cmos_mode |-> readback_out_pin == output_clock_negative)
        else $error("pin not carrying output clock in LVDS mode");
    AST_IDLE_LEVEL: assert property (
        cmos_mode && !rd_en |-> readback_out_pin == asrr_pkg::PIN_IDLE_LVL)
        else $error("pin not at idle level");
    AST_POWER_UP: assert property (
        $rose(stable_q) |-> $past(pu_cnt_q) == PUW'(PWR_UP_CYC - 1))
        else $error("outputs stable at wrong time");
    AST_FULL_WRITE: assert property (
        wr_ok && !init_regs |=> regs_q[$past(wr_idx)] == $past(wr_val))
        else $error("write did not update whole register");
    AST_FORMAT: assert property (
        wr_ok && !init_regs && wr_addr == asrr_pkg::ADDR_FORMAT
        |=> cfg.data_format == $past(sh_next[4]))
        else $error("data format bit not updated");
    AST_SOFT_RESET: assert property (
        srst |=> regs_q[20] == asrr_pkg::REG_RESET && !rd_en ##1 !srst)
        else $error("soft reset did not restore defaults");
    AST_SAMPLE: assert property (
        take |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
        else $error("shift clock fall not sampled");
    AST_MSB_FIRST: assert property (
        sclk_rise && bit_cnt_q[3] && !ser_s_q.sel_n && !addr_done
        |=> out_bit_q == $past(out_sh_q[7]))
        else $error("readback bit order wrong");

    COV_WRITE: cover property (wr_ok && !rd_en);
    COV_READBACK: cover property (addr_done && rd_en && cmos_mode);
    COV_BLOCKED: cover property (word_done && rd_en && !wr_ok);
    COV_SRST: cover property (srst);

endmodule : asrr_regbank

// ==== asrr_ctrl_model.sv ====
/*
 * Behavioural model of the external controller on the three-wire link.
 * Assumes the caller spaces frames; inputs change on sys_clk falling edges.
 */
`timescale 1ns/100ps
module asrr_ctrl_model (
    input  wire logic          sys_clk,
    input  wire logic          readback_out_pin,
    output asrr_pkg::asrr_ser_t ser,
    output logic [7:0]         rd_data,
    output logic               rd_done
);
    initial begin
        ser     = '{sel_n: 1'b1, sclk: 1'b0, shift_in_line: 1'b0};
        rd_data = 8'h00;
        rd_done = 1'b0;
    end

    // Select waits two sys_clk cycles before going low, whatever the reset state
    task automatic open_frame();
        repeat (2) @(negedge sys_clk);
        ser.sel_n = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : open_frame

    task automatic close_frame();
        repeat (2) @(negedge sys_clk);
        ser.sel_n = 1'b1;
        // Released data line must not keep its last value
        ser.shift_in_line = ~ser.shift_in_line;
        repeat (6) @(negedge sys_clk);
    endtask : close_frame

    // Address byte then data byte, MSB first; short counts abort
    task automatic word(input logic [7:0] a, input logic [7:0] d,
                        input int nbits, input bit rd);
        logic [15:0] w;
        logic [7:0]  cap;
        w   = {a, d};
        cap = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            // Data changes only while sclk is high, stable over the fall
            ser.sclk  = 1'b1;
            ser.shift_in_line = w[15-i];
            repeat (6) @(negedge sys_clk);
            if (i >= 8) begin
                cap = {cap[6:0], readback_out_pin};
            end
            ser.sclk = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        rd_data = cap;
        if (rd) begin
            rd_done = 1'b1;
            @(negedge sys_clk);
            rd_done = 1'b0;
        end
    endtask : word
endmodule : asrr_ctrl_model

// ==== asrr_regbank_tb_top.sv ====
/*
 * Self-checking bench of the serial register bank with readback.
 * Assumes the controller model in asrr_ctrl_model.sv; 20 MHz sys_clk.
 */
`timescale 1ns/100ps
module asrr_regbank_tb_top;
    localparam int PWR = 20;
    logic                sys_clk, rst_n, reset_pin, ocn, pin, stable, rd_done;
    asrr_pkg::asrr_ser_t ser;
    asrr_pkg::asrr_cfg_t cfg;
    logic [143:0]        coef;
    logic [7:0]          rd_data;
    logic [7:0]          exp_q[$];
    logic [31:0]         seed = 32'h1175;
    int                  miscompares = 0, n_tests = 0, cyc = 0;
    logic [7:0] addrs [14] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16,
        8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h2F};
    logic [7:0] masks [14] = '{8'hC0, 8'h3F, 8'h3F, 8'h10, 8'hBF, 8'h1F,
        8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hBF, 8'h03, 8'hFF, 8'hFF};
    logic [7:0] v [14];
    asrr_pkg::asrr_cfg_t ecfg;

    asrr_regbank #(.PWR_UP_CYC(PWR)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .ser_in(ser),
        .reset_pin(reset_pin), .output_clock_negative(ocn),
        .readback_out_pin(pin), .cfg(cfg), .coef_bank(coef),
        .outputs_stable(stable));
    asrr_ctrl_model ctl (
        .sys_clk(sys_clk), .readback_out_pin(pin), .ser(ser),
        .rd_data(rd_data), .rd_done(rd_done));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    always @(posedge rd_done) begin
        check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctl.open_frame();
        ctl.word(a, d, 16, 1'b0);
        ctl.close_frame();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        ctl.open_frame();
        ctl.word(a, 8'h00, 16, 1'b1);
        ctl.close_frame();
    endtask : rd

    initial begin
        rst_n     = 1'b0;
        reset_pin = 1'b0;
        ocn       = 1'b1;
        repeat (20) @(negedge sys_clk);
        check({15'h0, pin}, {15'h0, ocn});
        rst_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        check({15'h0, stable}, 16'h0000);
        repeat (PWR) @(negedge sys_clk);
        check({15'h0, stable}, 16'h0001);
        rd(8'h14, 8'hFF);
        ocn = 1'b0;
        rd(8'h14, 8'h00);
        $display("Test interface select done");
        wr(8'h14, 8'h20);
        check({15'h0, cfg.iface_sel}, 16'h0001);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 14; i++) begin
            v[i] = rnd() | ((addrs[i] == 8'h14) ? 8'h20 : 8'h00);
            wr(addrs[i], v[i]);
            v[i] = v[i] & masks[i];
        end
        check({15'h0, cfg.data_format}, {15'h0, v[5][4]});
        check({9'h0, cfg.pin_override, cfg.iface_sel, cfg.coarse_gain,
               cfg.ref_sel, cfg.pdn_mux_mode},
              {9'h0, v[4][7], v[4][5:0]});
        check({coef[143:136], coef[7:0]}, {v[13], v[12]});
        // Every field of the twelve written cfg registers, in carrier order
        ecfg = {v[0][7:6], v[1][5:0], v[2][5:0], v[3][4], v[4][7],
                v[4][5:0], v[5][4:0], v[6][3:0], v[8][5:0], v[7], v[9],
                v[10], v[11][1:0]};
        check({15'h0, cfg == ecfg}, 16'h0001);
        $display("Test register writes done");
        // Readback on, then the 14 written registers in one select with noisy data
        wr(8'h00, 8'h01);
        ctl.open_frame();
        for (int i = 0; i < 14; i++) begin
            exp_q.push_back(v[i]);
            ctl.word(addrs[i], rnd(), 16, 1'b1);
        end
        ctl.close_frame();
        rd(8'h15, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h16, ~v[5]);
        rd(8'h16, v[5]);
        $display("Test readback done");
        ctl.open_frame();
        ctl.word(8'h00, 8'h00, 12, 1'b0);
        ctl.close_frame();
        rd(8'h16, v[5]);
        // Clearing readback, with excess bits after the word
        ctl.open_frame();
        ctl.word(8'h00, 8'h00, 16, 1'b0);
        ctl.word(8'h16, 8'hFF, 5, 1'b0);
        ctl.close_frame();
        rd(8'h16, 8'h00);
        wr(8'h16, 8'h15);
        check({15'h0, cfg.data_format}, 16'h0001);
        $display("Test abort and resume done");
        wr(8'h00, 8'h02);
        check({15'h0, cfg == '0}, 16'h0001);
        check({15'h0, pin}, {15'h0, ocn});
        $display("Test soft reset done");
        wr(8'h17, 8'h0F);
        check({12'h0, cfg.fine_gain}, 16'h000F);
        // Pulse comes long after power-up is reported stable
        reset_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({12'h0, cfg.fine_gain}, 16'h0000);
        wr(8'h17, 8'h0A);
        check({12'h0, cfg.fine_gain}, 16'h0000);
        reset_pin = 1'b0;
        wr(8'h17, 8'h05);
        check({12'h0, cfg.fine_gain}, 16'h0005);
        $display("Test hardware reset done");
        stop_test();
    end
endmodule : asrr_regbank_tb_top
